// ===== rtl/pccm_pkg.sv
// package of constants and carriers for the capability configuration map
package pccm_pkg;
	// ------------------------------------------------------------
	// configuration vector field positions
	// ------------------------------------------------------------
	localparam int CFG_W = 224;
	localparam int L1_ACC_LO = 137;
	localparam int L1_ACC_HI = 139;
	localparam int RSV_A_LO = 140;
	localparam int RSV_A_HI = 145;
	localparam int LINK_W_LO = 146;
	localparam int LINK_W_HI = 151;
	localparam int ASPM_LO = 152;
	localparam int ASPM_HI = 153;
	localparam int EXIT_A_LO = 154;
	localparam int EXIT_A_HI = 156;
	localparam int EXIT_B_LO = 157;
	localparam int EXIT_B_HI = 159;
	localparam int RSV_B_LO = 160;
	localparam int RSV_B_HI = 166;
	localparam int TAGS_LO = 167;
	localparam int TAGS_HI = 169;
	localparam int RSV_C_LO = 170;
	localparam int RSV_C_HI = 191;
	localparam int FTS_SEP_LO = 192;
	localparam int FTS_SEP_HI = 199;
	localparam int FTS_COM_LO = 200;
	localparam int FTS_COM_HI = 207;
	localparam int PORT_LO = 208;
	localparam int PORT_HI = 215;
	localparam int ECRC_CHK_BIT = 216;
	localparam int ECRC_GEN_BIT = 217;
	localparam int RSV_D_BIT = 218;
	localparam int MSI_MMC_LO = 219;
	localparam int MSI_MMC_HI = 221;
	localparam int MSI_64_BIT = 222;
	localparam int MSI_PVM_BIT = 223;

	// ------------------------------------------------------------
	// encodings
	// ------------------------------------------------------------
	localparam logic [5:0] WIDTH_X1 = 6'h01;
	localparam logic [5:0] WIDTH_X4 = 6'h04;
	localparam logic [1:0] ASPM_L0S = 2'h1;
	localparam logic [1:0] ASPM_L1_L0S = 2'h3;
	localparam logic [2:0] MMC_MAX = 3'h5;

	// ------------------------------------------------------------
	// APB register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] REG_DEV_CAP = 8'h00;
	localparam logic [7:0] REG_LINK_CAP = 8'h04;
	localparam logic [7:0] REG_FTS = 8'h08;
	localparam logic [7:0] REG_ERR_CAP = 8'h0c;
	localparam logic [7:0] REG_MSI_CTL = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_CONTROL = 8'h18;
	localparam logic [31:0] CONTROL_RST = 32'h00000000;

	// decoded capability fields
	typedef struct packed {
		logic [2:0] l1_acc_lat;
		logic [5:0] link_width;
		logic link_width_ok;
		logic [1:0] aspm;
		logic aspm_ok;
		logic [2:0] exit_common;
		logic [2:0] exit_separate;
		logic [2:0] tags;
		logic [7:0] fts_separate;
		logic [7:0] fts_common;
		logic [7:0] port_num;
		logic ecrc_chk;
		logic ecrc_gen;
		logic [2:0] msi_mmc;
		logic msi_mmc_ok;
		logic msi_64;
		logic msi_pvm;
		logic rsv_nonzero;
	} pccm_caps_t;

	// APB slave side signals
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} pccm_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} pccm_apb_rsp_t;
endpackage

// ===== rtl/pccm_decode.sv
// decoder from the static configuration vector to capability fields
`timescale 1ns/1ps
module pccm_decode (
	input wire logic [pccm_pkg::CFG_W-1:0] cfg_vec,
	output pccm_pkg::pccm_caps_t caps
);
	import pccm_pkg::*;

	// field slicing; reserved ranges only feed a diagnostic flag
	always_comb begin
		caps = '0;
		caps.l1_acc_lat = cfg_vec[L1_ACC_HI:L1_ACC_LO];
		caps.link_width = cfg_vec[LINK_W_HI:LINK_W_LO];
		caps.link_width_ok = (caps.link_width == WIDTH_X1) ||
			(caps.link_width == WIDTH_X4);
		caps.aspm = cfg_vec[ASPM_HI:ASPM_LO];
		caps.aspm_ok = (caps.aspm == ASPM_L0S) ||
			(caps.aspm == ASPM_L1_L0S);
		// label says common for the low field; we follow the labels
		caps.exit_common = cfg_vec[EXIT_A_HI:EXIT_A_LO];
		caps.exit_separate = cfg_vec[EXIT_B_HI:EXIT_B_LO];
		caps.tags = cfg_vec[TAGS_HI:TAGS_LO];
		caps.fts_separate = cfg_vec[FTS_SEP_HI:FTS_SEP_LO];
		caps.fts_common = cfg_vec[FTS_COM_HI:FTS_COM_LO];
		caps.port_num = cfg_vec[PORT_HI:PORT_LO];
		caps.ecrc_chk = cfg_vec[ECRC_CHK_BIT];
		caps.ecrc_gen = cfg_vec[ECRC_GEN_BIT];
		caps.msi_mmc = cfg_vec[MSI_MMC_HI:MSI_MMC_LO];
		caps.msi_mmc_ok = (caps.msi_mmc <= MMC_MAX);
		caps.msi_64 = cfg_vec[MSI_64_BIT];
		caps.msi_pvm = cfg_vec[MSI_PVM_BIT];
		caps.rsv_nonzero = (|cfg_vec[RSV_A_HI:RSV_A_LO]) |
			(|cfg_vec[RSV_B_HI:RSV_B_LO]) |
			(|cfg_vec[RSV_C_HI:RSV_C_LO]) |
			cfg_vec[RSV_D_BIT];
	end
endmodule

// ===== rtl/pccm_map.sv
// capability configuration map: register bank with an APB view
`timescale 1ns/1ps
// ------------------------------------------------------------
// Notes on behaviour
// - Device capability L1 acceptable latency comes from bits 139:137.
// - Maximum link width comes from bits 151:146; only 1 and 4 valid.
// - ASPM support comes from bits 153:152; 01 is L0s, 11 is L1 and L0s.
// - Two L1 exit latency codes come from bits 156:154 and 159:157.
// - Supported tag count for sent non-posted requests is bits 169:167.
// - Fast training counts: separate clock 199:192, common 207:200.
// - Link port number comes from bits 215:208.
// - ECRC check capability is bit 216, ECRC generation bit 217.
// - MSI 64-bit address capability is bit 222.
// - MSI per-vector masking is bit 223 and cannot be written.
// ------------------------------------------------------------
module pccm_map (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [pccm_pkg::CFG_W-1:0] cfg_vec,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	output pccm_pkg::pccm_caps_t caps_out
);
	import pccm_pkg::*;

	// all checks run on the bus clock and rest while reset is low
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		pccm_caps_t caps;
		logic [31:0] rdata;
		logic slverr;
		logic [31:0] control;
	} pccm_state_t;

	pccm_state_t st;
	pccm_state_t next_st;
	pccm_caps_t dec_caps;
	pccm_apb_req_t req;

	assign req = '{psel: psel, penable: penable, pwrite: pwrite,
		paddr: paddr, pwdata: pwdata};

	// vector is static, so no synchroniser; we only register it
	pccm_decode u_decode (
		.cfg_vec(cfg_vec),
		.caps(dec_caps)
	);

	// register word assembly; reserved bits stay zero
	function automatic logic [31:0] read_word(input pccm_caps_t c,
			input logic [31:0] ctl, input logic [7:0] a);
		logic [31:0] w;
		w = 32'h00000000;
		case (a)
			REG_DEV_CAP: begin
				w[2:0] = c.l1_acc_lat;
				w[6:4] = c.tags;
			end
			REG_LINK_CAP: begin
				w[5:0] = c.link_width;
				w[9:8] = c.aspm;
				w[14:12] = c.exit_common;
				w[18:16] = c.exit_separate;
				w[31:24] = c.port_num;
			end
			REG_FTS: begin
				w[7:0] = c.fts_separate;
				w[15:8] = c.fts_common;
			end
			REG_ERR_CAP: begin
				w[0] = c.ecrc_chk;
				w[1] = c.ecrc_gen;
			end
			REG_MSI_CTL: begin
				w[2:0] = c.msi_mmc;
				w[3] = c.msi_64;
				w[4] = c.msi_pvm;
			end
			REG_STATUS: begin
				w[0] = c.link_width_ok;
				w[1] = c.aspm_ok;
				w[2] = c.msi_mmc_ok;
				w[3] = c.rsv_nonzero;
			end
			REG_CONTROL: w = ctl;
			default: w = 32'h00000000;
		endcase
		return w;
	endfunction

	function automatic logic addr_known(input logic [7:0] a);
		logic k;
		k = 1'b0;
		case (a)
			REG_DEV_CAP, REG_LINK_CAP, REG_FTS, REG_ERR_CAP,
			REG_MSI_CTL, REG_STATUS, REG_CONTROL: k = 1'b1;
			default: k = 1'b0;
		endcase
		return k;
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// zero-wait slave: access phase completes on its first edge
	always_comb begin
		next_st = st;
		// control bit 0 freezes the snapshot, e.g. across a re-strap
		if (!st.control[0]) begin
			next_st.caps = dec_caps;
		end
		next_st.slverr = 1'b0;
		if (req.psel && !req.penable) begin
			next_st.rdata = read_word(st.caps, st.control, req.paddr);
			// writes to read-only capability words are refused
			next_st.slverr = !addr_known(req.paddr) ||
				(req.pwrite && req.paddr != REG_CONTROL);
		end
		if (req.psel && req.penable && req.pwrite &&
				req.paddr == REG_CONTROL) begin
			next_st.control = req.pwdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st.caps <= '0;
			st.rdata <= 32'h00000000;
			st.slverr <= 1'b0;
			st.control <= CONTROL_RST;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign pready = 1'b1;
	assign pslverr = st.slverr && psel && penable;
	assign prdata = st.rdata;
	assign caps_out = st.caps;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// setup phase of a read from one word
	sequence s_setup_rd(logic [7:0] a);
		psel && !penable && !pwrite && paddr == a;
	endsequence

	// setup phase of a write to one word
	sequence s_setup_wr(logic [7:0] a);
		psel && !penable && pwrite && paddr == a;
	endsequence

	// access phase that closes the transfer
	sequence s_access;
		psel && penable;
	endsequence

	AST_L1_LAT: assert property (
		!st.control[0] |=> caps_out.l1_acc_lat ==
		$past(cfg_vec[L1_ACC_HI:L1_ACC_LO]))
		else $error("l1 latency field mismatch");
	AST_WIDTH: assert property (
		!st.control[0] |=> caps_out.link_width ==
		$past(cfg_vec[LINK_W_HI:LINK_W_LO]))
		else $error("link width mismatch");
	AST_ASPM: assert property (
		s_setup_rd(REG_LINK_CAP) |=> prdata[9:8] ==
		$past(caps_out.aspm))
		else $error("aspm read mismatch");
	AST_EXIT: assert property (
		s_setup_rd(REG_LINK_CAP) |=> prdata[18:12] ==
		{$past(caps_out.exit_separate), 1'b0,
		$past(caps_out.exit_common)})
		else $error("exit latency read mismatch");
	AST_TAGS: assert property (
		s_setup_rd(REG_DEV_CAP) |=> prdata[6:4] ==
		$past(caps_out.tags))
		else $error("tag count read mismatch");
	AST_TAGS_CAP: assert property (
		!st.control[0] |=> caps_out.tags ==
		$past(cfg_vec[TAGS_HI:TAGS_LO]))
		else $error("tag count field mismatch");
	AST_FTS: assert property (
		s_setup_rd(REG_FTS) |=> prdata[15:0] ==
		{$past(caps_out.fts_common), $past(caps_out.fts_separate)})
		else $error("fast training count mismatch");
	AST_FTS_CAP: assert property (
		!st.control[0] |=>
		{caps_out.fts_common, caps_out.fts_separate} ==
		$past(cfg_vec[FTS_COM_HI:FTS_SEP_LO]))
		else $error("fast training field mismatch");
	AST_PORT: assert property (
		s_setup_rd(REG_LINK_CAP) |=> prdata[31:24] ==
		$past(caps_out.port_num))
		else $error("port number mismatch");
	AST_ECRC: assert property (
		!st.control[0] |=> {caps_out.ecrc_gen, caps_out.ecrc_chk} ==
		$past(cfg_vec[ECRC_GEN_BIT:ECRC_CHK_BIT]))
		else $error("ecrc capability mismatch");
	AST_ERR_RSV: assert property (
		s_setup_rd(REG_ERR_CAP) |=> prdata[31:2] == 30'h00000000)
		else $error("error capability word not clean");
	AST_MSI_MMC: assert property (
		s_setup_rd(REG_MSI_CTL) |=> prdata[2:0] ==
		$past(caps_out.msi_mmc) && prdata[31:5] == 27'h0000000)
		else $error("msi message field mismatch");
	AST_MSI_64: assert property (
		!st.control[0] |=> caps_out.msi_64 ==
		$past(cfg_vec[MSI_64_BIT]))
		else $error("msi 64-bit flag mismatch");
	AST_PVM_CAP: assert property (
		!st.control[0] |=> caps_out.msi_pvm ==
		$past(cfg_vec[MSI_PVM_BIT]))
		else $error("per-vector mask field mismatch");
	AST_PVM_RO: assert property (
		psel && penable && pwrite && paddr == REG_MSI_CTL |->
		pslverr)
		else $error("write to msi control not refused");
	AST_RO_KEEP: assert property (
		s_setup_wr(REG_MSI_CTL) ##1 s_access |=> $stable(st.control))
		else $error("refused write changed state");
	AST_RSV_ZERO: assert property (
		s_setup_rd(REG_DEV_CAP) |=> prdata[31:7] == 25'h0000000 &&
		prdata[3] == 1'b0)
		else $error("reserved bits not zero");
	// the control word is the one place a write lands
	AST_CTL_WR: assert property (
		s_setup_wr(REG_CONTROL) ##1 s_access |=>
		st.control == $past(pwdata))
		else $error("control write lost");
	// words past the map answer with an error and no data
	AST_UNMAPPED: assert property (
		(psel && !penable && paddr > REG_CONTROL) ##1 s_access |->
		pslverr && prdata == 32'h00000000)
		else $error("unmapped access not refused");
	// a frozen snapshot must not follow the vector
	AST_FREEZE: assert property (
		st.control[0] |=> $stable(caps_out))
		else $error("frozen snapshot moved");
endmodule

// ===== tb/pccm_host_model.sv
// host-side model that reads and writes the register bank over APB
`timescale 1ns/1ps
module pccm_host_model (
	input wire logic sys_clk,
	input wire pccm_pkg::pccm_apb_rsp_t rsp,
	output pccm_pkg::pccm_apb_req_t req
);
	import pccm_pkg::*;

	// bus idle from time zero
	initial begin
		req = '0;
	end

	// ------------------------------------------------------------
	// one APB transfer
	// ------------------------------------------------------------
	// holds the request until pready is seen; only the bench
	// watchdog ends the wait on a dead slave
	// the answer is looked at mid-cycle, where it has settled for
	// the rising edge that closes the access phase
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		logic rdy;
		@(posedge sys_clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
			pwdata: d};
		@(posedge sys_clk);
		req.penable <= 1'b1;
		do begin
			@(negedge sys_clk);
			rdy = rsp.pready;
			q = rsp.prdata;
			e = rsp.pslverr;
			@(posedge sys_clk);
		end while (rdy !== 1'b1);
		// released address and data lines show inverted values; pwrite keeps its old value
		req <= '{psel: 1'b0, penable: 1'b0, pwrite: w, paddr: ~a,
			pwdata: ~d};
	endtask
endmodule

// ===== tb/pccm_map_tb_top.sv
// self-checking testbench of the capability configuration map
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin \
	checks_done++; \
	if ((gt) !== (ex)) begin \
		err_count++; \
		$display("[ERR] %s exp %h got %h", nm, ex, gt); \
	end \
end
module pccm_map_tb_top;
	import pccm_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [CFG_W-1:0] cfg_vec = '0;
	pccm_apb_req_t req;
	wire pccm_apb_rsp_t rsp;
	pccm_caps_t caps_out;
	int err_count = 0;
	int checks_done = 0;
	logic [31:0] q;
	logic e;

	// 40 MHz clock
	always #12.5 sys_clk = ~sys_clk;

	pccm_map i_pccm_map (.sys_clk(sys_clk), .rst_n(rst_n),
		.cfg_vec(cfg_vec), .psel(req.psel), .penable(req.penable),
		.pwrite(req.pwrite), .paddr(req.paddr), .pwdata(req.pwdata),
		.pready(rsp.pready), .pslverr(rsp.pslverr),
		.prdata(rsp.prdata), .caps_out(caps_out));
	pccm_host_model i_pccm_host_model (.sys_clk(sys_clk), .rsp(rsp),
		.req(req));

	// ------------------------------------------------------------
	// expectations and helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] exp_reg(input logic [7:0] a,
		input logic [CFG_W-1:0] v);
		logic rsv;
		rsv = |{v[145:140], v[166:160], v[191:170], v[218]};
		case (a)
			REG_DEV_CAP: return {25'h0, v[169:167], 1'b0, v[139:137]};
			REG_LINK_CAP: return {v[215:208], 5'h0, v[159:157], 1'b0,
				v[156:154], 2'h0, v[153:152], 2'h0, v[151:146]};
			REG_FTS: return {16'h0, v[207:200], v[199:192]};
			REG_ERR_CAP: return {30'h0, v[217], v[216]};
			REG_MSI_CTL: return {27'h0, v[223], v[222], v[221:219]};
			default: return {28'h0, rsv, v[221:219] <= 3'h5,
				(v[153:152] == 2'h1) || (v[153:152] == 2'h3),
				(v[151:146] == 6'h01) || (v[151:146] == 6'h04)};
		endcase
	endfunction

	// mixed patterns, then clean legal encodings of both kinds
	function automatic logic [CFG_W-1:0] pat(input int k);
		logic [CFG_W-1:0] v;
		v = {7{32'ha5c396e1}};
		if (k == 1) v = ~v;
		if (k >= 2) v = '0;
		if (k == 2) begin
			v[159:137] = {3'h6, 3'h1, 2'h3, 6'h04, 6'h00, 3'h7};
			v[169:167] = 3'h5;
			v[223:192] = {2'h2, 3'h5, 3'h1, 8'h5a, 8'h3c, 8'h81};
		end
		if (k == 3) begin
			v[153:146] = {2'h1, 6'h01};
			v[223:216] = 8'heb;
		end
		return v;
	endfunction

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex);
		i_pccm_host_model.xfer(1'b0, a, 32'h0, q, e);
		`CHK("prdata", ex, q)
		`CHK("pslverr", 1'b0, e)
	endtask

	// read one word and hold it against the present vector
	task automatic rd_now(input logic [7:0] a);
		rd_chk(a, exp_reg(a, cfg_vec));
	endtask

	task automatic results();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rd_chk(REG_CONTROL, CONTROL_RST);
		for (int k = 0; k < 4; k++) begin
			@(posedge sys_clk);
			cfg_vec <= pat(k);
			repeat (2) @(posedge sys_clk);
			rd_now(REG_DEV_CAP);
			rd_now(REG_LINK_CAP);
			rd_now(REG_FTS);
			rd_now(REG_ERR_CAP);
			rd_now(REG_MSI_CTL);
			rd_now(REG_STATUS);
			`CHK("caps_port", cfg_vec[215:208], caps_out.port_num)
			`CHK("caps_pvm", cfg_vec[223], caps_out.msi_pvm)
		end
		// a write to the read-only message control word is refused
		i_pccm_host_model.xfer(1'b1, REG_MSI_CTL, 32'hffffffff, q, e);
		`CHK("wr_ro_err", 1'b1, e)
		rd_now(REG_MSI_CTL);
		// unmapped address answers with an error and zero data
		i_pccm_host_model.xfer(1'b0, 8'h1c, 32'h0, q, e);
		`CHK("unmapped_err", 1'b1, e)
		`CHK("unmapped_data", 32'h0, q)
		// the only writable word takes a value and gives it back
		i_pccm_host_model.xfer(1'b1, REG_CONTROL, 32'h00000001, q, e);
		`CHK("wr_ctl_err", 1'b0, e)
		rd_chk(REG_CONTROL, 32'h00000001);
		// a frozen snapshot ignores a new vector until released
		cfg_vec <= pat(2);
		repeat (2) @(posedge sys_clk);
		rd_chk(REG_DEV_CAP, exp_reg(REG_DEV_CAP, pat(3)));
		i_pccm_host_model.xfer(1'b1, REG_CONTROL, 32'h00000000, q, e);
		rd_chk(REG_CONTROL, 32'h00000000);
		rd_now(REG_DEV_CAP);
		// reset in mid-run clears the control word and the snapshot
		i_pccm_host_model.xfer(1'b1, REG_CONTROL, 32'h00000001, q, e);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		@(posedge sys_clk);
		`CHK("caps_rst", 1'b0, |caps_out)
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rd_chk(REG_CONTROL, CONTROL_RST);
		rd_now(REG_LINK_CAP);
		results();
	end

	// watchdog: the sequence needs a few hundred cycles at most
	initial begin
		repeat (5000) @(posedge sys_clk);
		err_count++;
		results();
	end
endmodule
